/* src/apss_sequencer.sv */
// Purpose: ACPI power-state sequencer, processor C and system S/G states
// Assumes: all event pins are asynchronous; registers over Avalon-MM
// Notes: one answer cycle per bus request; SMI/SCI left to other logic
//
// Functional notes
// - C0 halt/level reads enter C1/C2/C3/C4
// - C0 sleep-enter, override S5, failure G3
// - C1 break to C0, stop-clock to C2
// - C2-C4 break C0, stop release returns C1
// - sleep states wake to C0, override, failure
// - power return reboots or stays in S5
// - latched wake events survive power failure
// - battery low holds off entry into S0
// - lower processor voltage in C4, S1-M
// - C3 stops CPU clock after stop-grant
// - C4 lowers voltage, restores before exit
// - power return uses prior state, select bit
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module apss_sequencer
    import apss_pkg::*;
#(
    parameter int NUM_EVT = 4
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // processor and event pins
    input wire logic cpuHalt,
    input wire logic stopGrant,
    input wire logic [NUM_EVT-1:0] breakEvt,
    input wire logic [NUM_EVT-1:0] wakeEvt,
    input wire logic pwrBtnOverride,
    input wire logic powerFail,
    input wire logic battery_low_n,
    // power control outputs
    output logic stop_clock_request_n,
    output logic cpu_clock_stop_n,
    output logic cpuVoltageLow,
    output logic sleep_s1_out_n,
    output logic sleep_s3_out_n,
    output logic sleep_s4_out_n
);
    import apss_pkg::*;

    // ----------------------------------------------------------------
    // parameter check
    // ----------------------------------------------------------------
    if (NUM_EVT < 1 || NUM_EVT > 8)
    begin : g_bad_evt
        $error("NUM_EVT must be 1 to 8");
    end

    localparam int SW = 2 * NUM_EVT + 5;  // synchronised pin count
    localparam logic [7:0] RAMP_LOAD = 8'(VOLT_RAMP_CYC);
    // idle pin levels; battery pin idles high so no false low-battery after reset
    localparam logic [SW-1:0] SYNC_IDLE = {1'b1, {(SW-1){1'b0}}};

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [SW-1:0] syncA_r;  // first stage, read only by second
    logic [SW-1:0] syncB_r;  // usable pin levels
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            syncA_r <= SYNC_IDLE;
            syncB_r <= SYNC_IDLE;
        end
        else
        begin
            syncA_r <= {battery_low_n, powerFail, pwrBtnOverride, stopGrant, cpuHalt, wakeEvt, breakEvt};
            syncB_r <= syncA_r;
        end
    end
    logic [NUM_EVT-1:0] brkS;  // synced break events
    logic [NUM_EVT-1:0] wakeS;  // synced wake events
    logic haltS, grantS, pboS, failS, batLowS;
    assign brkS = syncB_r[NUM_EVT-1:0];
    assign wakeS = syncB_r[2*NUM_EVT-1:NUM_EVT];
    assign haltS = syncB_r[2*NUM_EVT];
    assign grantS = syncB_r[2*NUM_EVT+1];
    assign pboS = syncB_r[2*NUM_EVT+2];
    assign failS = syncB_r[2*NUM_EVT+3];
    assign batLowS = !syncB_r[2*NUM_EVT+4];  // battery low active

    // ----------------------------------------------------------------
    // registers and bus slave
    // ----------------------------------------------------------------
    logic [7:0] ctrl_r;  // control bits
    logic [2*NUM_EVT-1:0] enable_r;  // break then wake enables
    logic [NUM_EVT-1:0] wakeLatch_r;  // wakes kept through failure
    logic waitReq_r;  // low for the answer cycle
    logic [31:0] rdData_r;  // read answer
    apss_state_t state_r, state_nxt;
    apss_state_t preG3_r;  // state held before G3
    logic take;  // request accepted this edge
    logic slpGo, lvl2Go, lvl3Go, lvl4Go;  // one-cycle bus events
    assign take = (avs_read || avs_write) && !waitReq_r;
    assign slpGo = ctrl_r[CTRL_SLEEP_ENTER_BIT];
    assign lvl2Go = take && avs_read && avs_address == OFF_LVL2;
    assign lvl3Go = take && avs_read && avs_address == OFF_LVL3;
    assign lvl4Go = take && avs_read && avs_address == OFF_LVL4;

    // waitrequest drops for one cycle, one edge after the request
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            waitReq_r <= 1'b1;
        else if ((avs_read || avs_write) && waitReq_r)
            waitReq_r <= 1'b0;
        else
            waitReq_r <= 1'b1;
    end

    // read data prepared in the same cycle waitrequest drops
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            rdData_r <= '0;
        else if (avs_read && waitReq_r)
        begin
            case (avs_address)
                OFF_CTRL: rdData_r <= {24'h00_0000, ctrl_r};
                OFF_ENABLE: rdData_r <= 32'(enable_r);
                OFF_STATUS: rdData_r <= {16'h0000, 8'(wakeLatch_r), 4'h0, state_r};
                default: rdData_r <= 32'h0000_0000;  // level and unmapped read zero
            endcase
        end
    end

    // control register, sleep-enter clears itself after one cycle
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            ctrl_r <= CTRL_RESET[7:0];
        else if (take && avs_write && avs_address == OFF_CTRL)
            ctrl_r <= avs_writedata[7:0];
        else
            ctrl_r[CTRL_SLEEP_ENTER_BIT] <= 1'b0;
    end

    // enables
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            enable_r <= '0;
        else if (take && avs_write && avs_address == OFF_ENABLE)
            enable_r <= avs_writedata[2*NUM_EVT-1:0];
    end

    // ----------------------------------------------------------------
    // event qualification
    // ----------------------------------------------------------------
    logic brkAny, wakeAny, wakeGo;
    assign brkAny = |(brkS & enable_r[NUM_EVT-1:0]);
    assign wakeAny = |(wakeS & enable_r[2*NUM_EVT-1:NUM_EVT]) || |wakeLatch_r;
    assign wakeGo = wakeAny && !batLowS;

    // wake latch: set wins; cleared once back in S0
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            wakeLatch_r <= '0;
        else if (state_r == ST_C0)
            wakeLatch_r <= wakeS & enable_r[2*NUM_EVT-1:NUM_EVT];
        else
            wakeLatch_r <= wakeLatch_r | (wakeS & enable_r[2*NUM_EVT-1:NUM_EVT]);
    end

    // ----------------------------------------------------------------
    // C-state handshake and voltage
    // ----------------------------------------------------------------
    logic prevC1_r;  // C2-C4 entered from C1
    logic clkStop_r;  // processor clock stopped
    logic vLow_r;  // processor voltage lowered
    logic [7:0] ramp_r;  // voltage restore wait
    logic exitPend_r;  // break seen in C4, exit waits for the ramp
    logic inStop;
    assign inStop = state_r == ST_C3 || state_r == ST_C4;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            prevC1_r <= 1'b0;
        else if (state_r == ST_C1 && state_nxt == ST_C2)
            prevC1_r <= 1'b1;
        else if (state_nxt == ST_C0 || state_nxt == ST_C1)
            prevC1_r <= 1'b0;
    end

    // clock stop follows stop-grant in C3 and C4
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            clkStop_r <= 1'b0;
        else if (!inStop || state_nxt != state_r)
            clkStop_r <= 1'b0;
        else if (grantS)
            clkStop_r <= 1'b1;
    end

    // a short break in C4 is kept so that it still ends C4 once the ramp is over
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            exitPend_r <= 1'b0;
        else if (state_r != ST_C4)
            exitPend_r <= 1'b0;
        else if (brkAny)
            exitPend_r <= 1'b1;
    end

    // in C4 voltage lowered only after the clock stops; raised before exit
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            vLow_r <= 1'b0;
            ramp_r <= '0;
        end
        else if (state_r == ST_C4 && brkAny && vLow_r)
        begin
            vLow_r <= 1'b0;
            ramp_r <= RAMP_LOAD;
        end
        else if (state_r == ST_C4 && clkStop_r && !brkAny && !exitPend_r && ramp_r == 8'h00)
            vLow_r <= 1'b1;
        else if (state_r == ST_S1M)
            vLow_r <= ctrl_r[CTRL_DEEPER];
        else if (state_r != ST_C4)
            vLow_r <= 1'b0;
        if (rst_b && ramp_r != 8'h00 && !(state_r == ST_C4 && brkAny && vLow_r))
            ramp_r <= ramp_r - 8'h01;
    end

    // ----------------------------------------------------------------
    // state machine
    // ----------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        if (failS)
            state_nxt = ST_G3;
        else if (pboS && state_r != ST_G3)
            state_nxt = ST_S5;
        else
        begin
            case (state_r)
                ST_C0:
                begin
                    if (slpGo)
                    begin
                        case (ctrl_r[CTRL_SLP_TYP_LO +: 3])
                            SLP_TYP_S1M: state_nxt = ST_S1M;
                            SLP_TYP_S3: state_nxt = ST_S3;
                            SLP_TYP_S4: state_nxt = ST_S4;
                            SLP_TYP_S5: state_nxt = ST_S5;
                            default: state_nxt = ST_C0;
                        endcase
                    end
                    else if (lvl2Go)
                        state_nxt = ST_C2;
                    else if (lvl3Go)
                        state_nxt = ctrl_r[CTRL_DEEP_C4] ? ST_C4 : ST_C3;
                    else if (lvl4Go)
                        state_nxt = ST_C4;
                    else if (haltS)
                        state_nxt = ST_C1;
                end
                ST_C1:
                begin
                    if (brkAny)
                        state_nxt = ST_C0;
                    else if (ctrl_r[CTRL_STOP_FORCE])
                        state_nxt = ST_C2;
                end
                ST_C2, ST_C3, ST_C4:
                begin
                    if ((brkAny || exitPend_r) && !vLow_r && ramp_r == 8'h00)
                        state_nxt = ST_C0;
                    else if (!brkAny && prevC1_r && !ctrl_r[CTRL_STOP_FORCE] && !vLow_r && ramp_r == 8'h00)
                        state_nxt = ST_C1;
                end
                ST_S1M, ST_S3, ST_S4, ST_S5:
                begin
                    if (wakeGo)
                        state_nxt = ST_C0;
                end
                ST_G3:
                begin
                    if (wakeGo || (!batLowS && !ctrl_r[CTRL_AFTER_LOSS] && preG3_r != ST_S5))
                        state_nxt = ST_C0;
                    else
                        state_nxt = ST_S5;
                end
                default: state_nxt = ST_C0;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            state_r <= ST_C0;
            preG3_r <= ST_C0;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_r != ST_G3)
                preG3_r <= state_r;
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            stop_clock_request_n <= 1'b1;
            cpu_clock_stop_n <= 1'b1;
            cpuVoltageLow <= 1'b0;
            sleep_s1_out_n <= 1'b1;
            sleep_s3_out_n <= 1'b1;
            sleep_s4_out_n <= 1'b1;
        end
        else
        begin
            stop_clock_request_n <= !(state_r inside {ST_C2, ST_C3, ST_C4} || ctrl_r[CTRL_STOP_FORCE]);
            cpu_clock_stop_n <= !clkStop_r;
            cpuVoltageLow <= vLow_r;
            sleep_s1_out_n <= state_r != ST_S1M;
            sleep_s3_out_n <= !(state_r inside {ST_S3, ST_S4, ST_S5, ST_G3});
            sleep_s4_out_n <= !(state_r inside {ST_S4, ST_S5, ST_G3});
        end
    end
    assign avs_readdata = rdData_r;
    assign avs_waitrequest = waitReq_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    chk_halt_to_c1: assert property (state_r == ST_C0 && haltS && !failS && !pboS && !slpGo && !lvl2Go && !lvl3Go
        && !lvl4Go |=> state_r == ST_C1) else $error("halt did not enter C1");
    chk_lvl3_deep: assert property (state_r == ST_C0 && lvl3Go && !failS && !pboS && !slpGo
        |=> state_r == (ctrl_r[CTRL_DEEP_C4] ? ST_C4 : ST_C3)) else $error("level 3 read wrong target");
    chk_fail_to_g3: assert property (failS |=> state_r == ST_G3) else $error("power failure missed");
    chk_override_s5: assert property (pboS && !failS && state_r != ST_G3 |=> state_r == ST_S5)
        else $error("override missed");
    chk_c1_break: assert property (state_r == ST_C1 && brkAny && !failS && !pboS |=> state_r == ST_C0)
        else $error("break left C1 wrong");
    chk_battery_low_n_hold: assert property (batLowS && state_r inside {ST_S1M, ST_S3, ST_S4, ST_S5, ST_G3}
        |=> state_r != ST_C0) else $error("S0 entered on battery low");
    chk_s1_output: assert property (state_r == ST_S1M |=> !sleep_s1_out_n) else $error("S1 output idle");
    chk_clkstop_grant: assert property ($fell(cpu_clock_stop_n) |-> $past(inStop, 2) && $past(grantS, 2))
        else $error("clock stopped without grant");
    chk_volt_order: assert property ($rose(cpuVoltageLow) && $past(state_r) == ST_C4 |-> !cpu_clock_stop_n)
        else $error("voltage lowered with clock running");
    chk_bus_answer: assert property ((avs_read || avs_write) && waitReq_r |=> !avs_waitrequest)
        else $error("bus answer late");

    cov_c4_entry: cover property (state_r == ST_C0 ##1 state_r == ST_C4);
    cov_wake_s3: cover property (state_r == ST_S3 ##1 state_r == ST_C0);
    cov_g3_return: cover property (state_r == ST_G3 ##1 state_r == ST_S5);
    cov_c2_back_c1: cover property (state_r == ST_C2 && prevC1_r ##1 state_r == ST_C1);
endmodule // apss_sequencer

/* include/apss_pkg.sv */
// Purpose: shared constants and types of the power-state sequencer
// Assumes: 20 MHz system clock, 32-bit Avalon-MM register port
// Notes: offsets are byte addresses of aligned words
package apss_pkg;
    // ----------------------------------------------------------------
    // power states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_C0 = 4'h0,
        ST_C1 = 4'h1,
        ST_C2 = 4'h2,
        ST_C3 = 4'h3,
        ST_C4 = 4'h4,
        ST_S1M = 4'h5,
        ST_S3 = 4'h6,
        ST_S4 = 4'h7,
        ST_S5 = 4'h8,
        ST_G3 = 4'h9
    } apss_state_t;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [4:0] OFF_CTRL = 5'h00;  // control bits
    localparam logic [4:0] OFF_ENABLE = 5'h04;  // break and wake enables
    localparam logic [4:0] OFF_LVL2 = 5'h08;  // read enters C2
    localparam logic [4:0] OFF_LVL3 = 5'h0C;  // read enters C3 or C4
    localparam logic [4:0] OFF_LVL4 = 5'h10;  // read enters C4
    localparam logic [4:0] OFF_STATUS = 5'h14;  // state and pin view
    // control fields
    localparam int CTRL_SLEEP_ENTER_BIT = 0;  // sleep_enter_bit, self clearing
    localparam int CTRL_SLP_TYP_LO = 1;  // sleep type, 3 bits
    localparam int CTRL_DEEP_C4 = 4;  // deep_c_on_c3_enable
    localparam int CTRL_AFTER_LOSS = 5;  // after_power_loss_select
    localparam int CTRL_DEEPER = 6;  // deeper sleep in S1-M
    localparam int CTRL_STOP_FORCE = 7;  // drive stop-clock request
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int ENA_WAKE_LO = 8;  // not used; wake enables start at bit NUM_EVT
    // sleep type codes
    localparam logic [2:0] SLP_TYP_S1M = 3'h1;
    localparam logic [2:0] SLP_TYP_S3 = 3'h3;
    localparam logic [2:0] SLP_TYP_S4 = 3'h4;
    localparam logic [2:0] SLP_TYP_S5 = 3'h5;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int VOLT_RAMP_NS = 10000;  // processor voltage restore time
    localparam int VOLT_RAMP_CYC = (VOLT_RAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* tb/apss_cpu_model.sv */
// Purpose: processor, clock generator and board power switches beside the sequencer
// Assumes: stop-grant follows stop-clock after a bench-set delay
// Notes: plane flags show what the board does with the sleep outputs
`timescale 1ns/1ps
module apss_cpu_model
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // sequencer outputs
    input wire logic stopReq_n,
    input wire logic s1_n,
    input wire logic s4_n,
    // bench control
    input wire logic haltReq,
    input wire logic [2:0] grantDly,
    // to sequencer and bench
    output logic cpuHalt,
    output logic stopGrant,
    output logic clkGenLow,
    output logic memPowered
);
    logic [2:0] cnt_r; // cycles since stop-clock went active
    // halt follows the bench; grant comes late and drops as soon as stop-clock is released
    always_ff @(posedge sys_clk)
    begin
        cpuHalt <= rst_b & haltReq;
        if (!rst_b || stopReq_n)
        begin
            cnt_r <= 3'h0;
            stopGrant <= 1'b0;
        end
        else if (cnt_r < grantDly)
            cnt_r <= cnt_r + 3'h1;
        else
            stopGrant <= 1'b1;
    end
    // generator idles in S1, processor power stays on
    assign clkGenLow = !s1_n;
    // memory kept through S3, cut to zero volts only in S4 and deeper
    assign memPowered = s4_n;
endmodule // apss_cpu_model

/* tb/acpi_power_state_sequencer_tb.sv */
// Purpose: self-checking bench of the power-state sequencer
// Assumes: NUM_EVT of 4, all break and wake enables set
// Notes: state is observed through the status register
`timescale 1ns/1ps
module acpi_power_state_sequencer_tb;
    import apss_pkg::*;
    localparam int N = 4;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic cpuHalt, stopGrant, clkGenLow, memPowered;
    logic haltReq = 1'b0;
    logic [2:0] grantDly = 3'h2;
    logic [N-1:0] breakEvt = '0, wakeEvt = '0;
    logic pwrBtnOverride = 1'b0, powerFail = 1'b0, battery_low_n = 1'b1;
    logic stop_clock_request_n, cpu_clock_stop_n, cpuVoltageLow;
    logic sleep_s1_out_n, sleep_s3_out_n, sleep_s4_out_n;
    int errors = 0, n_checks = 0, i;
    logic [31:0] lfsr = 32'hDFBF1371;
    logic [31:0] rd;
    // level-read addresses and the states they lead to
    logic [4:0] lvA [4] = '{OFF_LVL2, OFF_LVL3, OFF_LVL3, OFF_LVL4};
    apss_state_t lvS [4] = '{ST_C2, ST_C3, ST_C4, ST_C4};
    // sleep type codes and their states
    logic [2:0] typ [4] = '{SLP_TYP_S1M, SLP_TYP_S3, SLP_TYP_S4, SLP_TYP_S5};
    apss_state_t sst [4] = '{ST_S1M, ST_S3, ST_S4, ST_S5};
    always #25 sys_clk = ~sys_clk;
    apss_sequencer #(.NUM_EVT(N)) apss_sequencer_i (
        .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cpuHalt(cpuHalt), .stopGrant(stopGrant),
        .breakEvt(breakEvt), .wakeEvt(wakeEvt), .pwrBtnOverride(pwrBtnOverride),
        .powerFail(powerFail), .battery_low_n(battery_low_n),
        .stop_clock_request_n(stop_clock_request_n), .cpu_clock_stop_n(cpu_clock_stop_n),
        .cpuVoltageLow(cpuVoltageLow), .sleep_s1_out_n(sleep_s1_out_n),
        .sleep_s3_out_n(sleep_s3_out_n), .sleep_s4_out_n(sleep_s4_out_n));
    apss_cpu_model apss_cpu_model_i (
        .sys_clk(sys_clk), .rst_b(rst_b), .stopReq_n(stop_clock_request_n),
        .s1_n(sleep_s1_out_n), .s4_n(sleep_s4_out_n), .haltReq(haltReq), .grantDly(grantDly),
        .cpuHalt(cpuHalt), .stopGrant(stopGrant), .clkGenLow(clkGenLow), .memPowered(memPowered));
    // random source
    function automatic logic [31:0] next_rand();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    // expected sleep outputs {s1, s3, s4}, active low
    function automatic logic [2:0] exp_sleep(input apss_state_t s);
        return {s != ST_S1M, !(s inside {ST_S3, ST_S4, ST_S5, ST_G3}), !(s inside {ST_S4, ST_S5, ST_G3})};
    endfunction
    // one comparison
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // closing report
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one bus access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        for (k = 0; k < 20; k++)
        begin
            @(posedge sys_clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (k == 20)
        begin
            errors++;
            wrap_up();
        end
    endtask
    // poll status until the state shows, then let outputs settle
    task automatic wait_state(input apss_state_t s);
        int k;
        for (k = 0; k < 100; k++)
        begin
            bus(1'b0, OFF_STATUS, 32'h0);
            if (rd[3:0] === s)
                break;
        end
        check("state", {28'h0, rd[3:0]}, {28'h0, s});
        if (rd[3:0] !== s)
            wrap_up();
        repeat (2) @(posedge sys_clk);
    endtask
    // pulse one pin: 0 break, 1 wake, 2 override, 3 halt
    task automatic pulse(input int k);
        logic [N-1:0] b;
        b = '0;
        b[next_rand() % N] = 1'b1;
        @(posedge sys_clk);
        breakEvt <= (k == 0) ? b : '0;
        wakeEvt <= (k == 1) ? b : '0;
        pwrBtnOverride <= (k == 2);
        haltReq <= (k == 3);
        repeat (6) @(posedge sys_clk);
        breakEvt <= '0;
        wakeEvt <= '0;
        pwrBtnOverride <= 1'b0;
        haltReq <= 1'b0;
    endtask
    // main sequence
    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        check("idle outs", {26'h0, stop_clock_request_n, cpu_clock_stop_n, cpuVoltageLow,
            sleep_s1_out_n, sleep_s3_out_n, sleep_s4_out_n}, 32'h37);
        bus(1'b1, 5'h18, 32'hFFFF_FFFF);
        bus(1'b0, 5'h18, 32'h0);
        check("unmapped", rd, 32'h0);
        bus(1'b1, OFF_ENABLE, 32'h0000_00FF);
        // idle entry and break exit through every level read
        pulse(3);
        wait_state(ST_C1);
        pulse(0);
        wait_state(ST_C0);
        for (int k = 0; k < 4; k++)
        begin
            grantDly <= 3'(next_rand());
            bus(1'b1, OFF_CTRL, (k == 2) ? 32'h10 : 32'h0);
            bus(1'b0, lvA[k], 32'h0);
            wait_state(lvS[k]);
            check("stop req", {31'h0, stop_clock_request_n}, 32'h0);
            if (lvS[k] != ST_C2)
            begin
                for (i = 0; i < 60 && cpu_clock_stop_n !== 1'b0; i++) @(posedge sys_clk);
                check("clock stop", {31'h0, cpu_clock_stop_n}, 32'h0);
                check("grant at clock stop", {31'h0, stopGrant}, 32'h1);
            end
            if (lvS[k] == ST_C4)
            begin
                for (i = 0; i < 60 && cpuVoltageLow !== 1'b1; i++) @(posedge sys_clk);
                check("volt low", {31'h0, cpuVoltageLow}, 32'h1);
            end
            pulse(0);
            if (lvS[k] == ST_C4)
            begin
                check("volt restored", {31'h0, cpuVoltageLow}, 32'h0);
                bus(1'b0, OFF_STATUS, 32'h0);
                check("state in ramp", {28'h0, rd[3:0]}, {28'h0, ST_C4});
            end
            wait_state(ST_C0);
        end
        // stop-clock from halt, release back to halt, override to soft-off
        pulse(3);
        wait_state(ST_C1);
        bus(1'b1, OFF_CTRL, 32'h80);
        wait_state(ST_C2);
        bus(1'b1, OFF_CTRL, 32'h0);
        wait_state(ST_C1);
        pulse(2);
        wait_state(ST_S5);
        pulse(1);
        wait_state(ST_C0);
        // every sleep type, deeper sleep selected
        for (int t = 0; t < 4; t++)
        begin
            bus(1'b1, OFF_CTRL, 32'h41 | (32'(typ[t]) << 1));
            wait_state(sst[t]);
            check("sleep outs", {29'h0, sleep_s1_out_n, sleep_s3_out_n, sleep_s4_out_n},
                {29'h0, exp_sleep(sst[t])});
            check("board planes", {30'h0, clkGenLow, memPowered},
                {30'h0, sst[t] == ST_S1M, !(sst[t] inside {ST_S4, ST_S5})});
            if (sst[t] == ST_S1M)
                check("deeper sleep", {31'h0, cpuVoltageLow}, 32'h1);
            pulse(1);
            wait_state(ST_C0);
        end
        // unknown sleep type leaves the system running
        bus(1'b1, OFF_CTRL, 32'h05);
        bus(1'b0, OFF_STATUS, 32'h0);
        check("bad sleep type", {28'h0, rd[3:0]}, {28'h0, ST_C0});
        // power loss and return, select clear then set
        bus(1'b1, OFF_CTRL, 32'h0);
        powerFail <= 1'b1;
        wait_state(ST_G3);
        check("g3 outs", {29'h0, sleep_s1_out_n, sleep_s3_out_n, sleep_s4_out_n},
            {29'h0, exp_sleep(ST_G3)});
        powerFail <= 1'b0;
        wait_state(ST_C0);
        bus(1'b1, OFF_CTRL, 32'h20);
        powerFail <= 1'b1;
        wait_state(ST_G3);
        powerFail <= 1'b0;
        wait_state(ST_S5);
        // wake held off by low battery, kept across a power loss
        battery_low_n <= 1'b0;
        pulse(1);
        repeat (20) @(posedge sys_clk);
        bus(1'b0, OFF_STATUS, 32'h0);
        check("held by battery", {28'h0, rd[3:0]}, {28'h0, ST_S5});
        powerFail <= 1'b1;
        wait_state(ST_G3);
        powerFail <= 1'b0;
        repeat (20) @(posedge sys_clk);
        battery_low_n <= 1'b1;
        wait_state(ST_C0);
        wrap_up();
    end
endmodule // acpi_power_state_sequencer_tb
